// ---- src/itf_crc_step.sv ----
// itf_crc_step: one-byte step of an msb-first crc-32, no reflection.
// assumes the caller holds the running value and the init/final policy.
`timescale 1ns/10ps
module itf_crc_step (
  input wire logic [31:0] i_crc,
  input wire logic [7:0] i_byte,
  output logic [31:0] o_crc
);

  always_comb
  begin
    logic [31:0] c;
    c = i_crc;
    for (int b = 7; b >= 0; b--)
    begin
      if (c[31] ^ i_byte[b])
      begin
        c = {c[30:0], 1'b0} ^ itf_pkg::CRC_POLY; // RULE9
      end
      else
      begin
        c = {c[30:0], 1'b0};
      end
    end
    o_crc = c;
  end

endmodule

// ---- src/itf_framer.sv ----
// itf_framer: emits the inertial part of the packet tail as a byte stream
// and closes it with a crc-32/mpeg-2. assumes the packet builder pulses
// i_start once its earlier tail bytes are out and accepts bytes by o_ready.
//
// Function
// RULE1: acceleration factor 244, two bytes, unsigned
// RULE2: angular velocity factor 1750, two bytes, unsigned
// RULE3: four-byte timestamp after factors, 25 us steps
// RULE4: timestamp clears at reset, wraps at maximum
// RULE5: x acceleration, signed two bytes, after timestamp
// RULE6: y then z acceleration follow x
// RULE7: x, y, z angular velocity, signed two bytes
// RULE8: four-byte checksum over tail ends it
// RULE9: crc poly 04C11DB7, init ones, unreflected
`timescale 1ns/10ps
module itf_framer (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic i_start,
  input wire itf_pkg::itf_sample_t i_sample,
  input wire logic i_ready,
  output itf_pkg::itf_byte_t o_byte,
  output logic o_busy,
  output logic [31:0] o_timestamp
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  // every byte costs a load cycle and a present cycle: half rate, but the
  // crc step never sits between the state flops and o_byte
  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_SEND} itf_state_t;

  typedef struct packed {
    itf_state_t st;
    logic [11:0] tick;
    logic [31:0] ts;
    logic [159:0] fields;
    logic [4:0] idx;
    logic [31:0] crc;
    itf_pkg::itf_byte_t out;
  } itf_regs_t;

  itf_regs_t r_q;
  itf_regs_t r_d;
  logic [31:0] crc_next;
  logic [7:0] cur_byte;

  // big-endian byte pick over the 20 field bytes, then the 4 checksum bytes
  function automatic logic [7:0] pick(input logic [191:0] f, input logic [4:0] i);
    logic [7:0] res;
    res = 8'h00;
    for (int k = 0; k < int'(itf_pkg::TAIL_BYTES); k++)
    begin
      if (5'(k) == i)
      begin
        res = f[191 - 8 * k -: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------
  // checksum step
  // ----------------------------------------
  assign cur_byte = pick({r_q.fields, r_q.crc}, r_q.idx);

  itf_crc_step u_crc (
    .i_crc(r_q.crc),
    .i_byte(cur_byte),
    .o_crc(crc_next)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    logic take;
    take = r_q.out.valid && i_ready;
    r_d = r_q;
    // the step count halts with i_ce, so the timestamp only runs in enabled time
    if (r_q.tick == itf_pkg::TS_STEP_LAST) // RULE3
    begin
      r_d.tick = 12'h000;
      r_d.ts = r_q.ts + 32'h00000001; // RULE4
    end
    else
    begin
      r_d.tick = r_q.tick + 12'h001;
    end
    if (take)
    begin
      r_d.out.valid = 1'b0;
    end
    unique case (r_q.st)
      ST_IDLE:
      begin
        if (i_start)
        begin
          r_d.fields = {itf_pkg::ACC_FACTOR, // RULE1
                        itf_pkg::GYR_FACTOR, // RULE2
                        r_q.ts, // RULE3
                        i_sample.acc_x, // RULE5
                        i_sample.acc_y, i_sample.acc_z, // RULE6
                        i_sample.gyr_x, i_sample.gyr_y, i_sample.gyr_z}; // RULE7
          r_d.idx = 5'h00;
          r_d.crc = itf_pkg::CRC_INIT; // RULE9
          r_d.st = ST_LOAD;
        end
      end
      ST_LOAD:
      begin
        // field bytes fold into the checksum; checksum bytes do not
        r_d.out.valid = 1'b1;
        r_d.out.data = cur_byte;
        r_d.out.last = (r_q.idx == itf_pkg::TAIL_BYTES - 5'h01); // RULE8
        if (r_q.idx < itf_pkg::FIELD_BYTES)
        begin
          r_d.crc = crc_next;
        end
        r_d.st = ST_SEND;
      end
      ST_SEND:
      begin
        if (take)
        begin
          if (r_q.out.last)
          begin
            r_d.st = ST_IDLE;
          end
          else
          begin
            r_d.idx = r_q.idx + 5'h01;
            r_d.st = ST_LOAD;
          end
        end
      end
      default:
      begin
        r_d.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      r_q <= '0; // RULE4
      r_q.st <= ST_IDLE;
      r_q.ts <= itf_pkg::TS_RESET;
    end
    else if (i_ce)
    begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign o_byte = r_q.out;
  assign o_busy = (r_q.st != ST_IDLE);
  assign o_timestamp = r_q.ts;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst || !i_ce);

  a_first_byte_zero: assert property (o_byte.valid && r_q.idx == 5'h00 // RULE1
      |-> o_byte.data == 8'h00)
    else $error("first factor byte wrong");
  a_acc_low_byte: assert property (o_byte.valid && r_q.idx == 5'h01 // RULE1
      |-> o_byte.data == 8'hF4)
    else $error("acceleration factor wrong");
  a_gyr_high: assert property (o_byte.valid && r_q.idx == 5'h02 // RULE2
      |-> o_byte.data == 8'h06)
    else $error("angular factor high byte wrong");
  a_gyr_bytes: assert property (o_byte.valid && r_q.idx == 5'h03 |-> o_byte.data == 8'hD6) // RULE2
    else $error("angular factor wrong");
  a_ts_step: assert property (r_q.tick == itf_pkg::TS_STEP_LAST && i_ce // RULE3
      |=> r_q.ts == $past(r_q.ts) + 32'h00000001)
    else $error("timestamp step wrong");
  a_ts_hold: assert property (r_q.tick != itf_pkg::TS_STEP_LAST |=> $stable(r_q.ts)) // RULE4
    else $error("timestamp moved early");
  a_ts_snap: assert property (r_q.st == ST_IDLE && i_start // RULE3
      |=> r_q.fields[127:96] == $past(r_q.ts))
    else $error("timestamp not captured");
  a_fields_held: assert property (r_q.st != ST_IDLE |=> $stable(r_q.fields)) // RULE3
    else $error("fields changed mid tail");
  a_acc_order: assert property (r_q.st == ST_IDLE && i_start // RULE6
      |=> r_q.fields[95:48] == $past({i_sample.acc_x, i_sample.acc_y, i_sample.acc_z}))
    else $error("acceleration order wrong");
  a_gyr_order: assert property (r_q.st == ST_IDLE && i_start // RULE7
      |=> r_q.fields[47:0] == $past({i_sample.gyr_x, i_sample.gyr_y, i_sample.gyr_z}))
    else $error("angular order wrong");
  a_last_index: assert property (o_byte.valid && o_byte.last |-> r_q.idx == 5'h17) // RULE8
    else $error("tail length wrong");
  a_acc_x_pos: assert property (r_q.st == ST_IDLE && i_start // RULE5
      |=> r_q.fields[95:80] == $past(i_sample.acc_x))
    else $error("x acceleration misplaced");
  a_crc_start: assert property (r_q.st == ST_IDLE && i_start |=> r_q.crc == 32'hFFFFFFFF) // RULE9
    else $error("crc init wrong");
  a_crc_frozen: assert property (r_q.st == ST_LOAD && r_q.idx >= itf_pkg::FIELD_BYTES // RULE8
      |=> $stable(r_q.crc))
    else $error("checksum folded its own bytes");
  a_crc_msb: assert property (o_byte.valid && r_q.idx == itf_pkg::FIELD_BYTES // RULE8
      |-> o_byte.data == r_q.crc[31:24])
    else $error("checksum byte order wrong");
  a_byte_hold: assert property (o_byte.valid && !i_ready // RULE8
      |=> o_byte.valid && $stable(o_byte.data) && $stable(o_byte.last))
    else $error("byte dropped before accept");
  a_idle_quiet: assert property (!o_busy |-> !o_byte.valid) // RULE8
    else $error("byte offered while idle");

  c_frame_start: cover property (r_q.st == ST_IDLE && i_start);
  c_frame_end: cover property (o_byte.valid && o_byte.last && i_ready);
  c_stall: cover property (o_byte.valid && !i_ready ##1 o_byte.valid && i_ready);
  c_start_refused: cover property (o_busy && i_start);
  c_ts_step: cover property (r_q.tick == itf_pkg::TS_STEP_LAST);

endmodule

// ---- src/itf_pkg.sv ----
// itf_pkg: constants and carrier types for the inertial tail field framer.
// assumes one core clock at 125 MHz and a synchronous active-high reset.
package itf_pkg;

  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned TS_STEP_NS = 25000;
  localparam int unsigned TS_STEP_CYC = (TS_STEP_NS * 1000) / CLK_PERIOD_PS;
  localparam logic [11:0] TS_STEP_LAST = 12'(TS_STEP_CYC - 1);

  // ----------------------------------------
  // fixed fields
  // ----------------------------------------
  localparam logic [15:0] ACC_FACTOR = 16'h00F4;
  localparam logic [15:0] GYR_FACTOR = 16'h06D6;
  localparam logic [31:0] TS_RESET = 32'h00000000;

  // ----------------------------------------
  // checksum
  // ----------------------------------------
  localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;

  // ----------------------------------------
  // layout: 2+2+4+6*2 = 20 field bytes, then 4 checksum bytes
  // ----------------------------------------
  localparam logic [4:0] FIELD_BYTES = 5'h14;
  localparam logic [4:0] TAIL_BYTES = 5'h18;

  typedef struct packed {
    logic signed [15:0] acc_x;
    logic signed [15:0] acc_y;
    logic signed [15:0] acc_z;
    logic signed [15:0] gyr_x;
    logic signed [15:0] gyr_y;
    logic signed [15:0] gyr_z;
  } itf_sample_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
  } itf_byte_t;

endpackage

// ---- verification/itf_framer_tb_top.sv ----
// itf_framer_tb_top: row-driven bench of the inertial tail framer.
// assumes the host sink model and a 125 MHz core clock.
`timescale 1ns/10ps
module itf_framer_tb_top;
  typedef struct {itf_pkg::itf_sample_t s; logic slow; int gap; logic poke;} itf_row_t;
  logic clk = 0, rst = 1, ce = 1, start = 0, slow = 0, rdy, busy;
  itf_pkg::itf_sample_t smp = '0;
  itf_pkg::itf_byte_t ob;
  logic [31:0] ts, ts_seen;
  int bad_count = 0;
  int n_compared = 0;
  itf_row_t rows [3] = '{'{'0, 1'b0, 0, 1'b0},
    '{{16'h7FFF, 16'h8000, 16'hFFFF, 16'h0001, 16'h1234, 16'hEDCB}, 1'b1, 4, 1'b1},
    '{{6{16'hA55A}}, 1'b0, 0, 1'b0}};
  always #4 clk = ~clk;
  itf_framer DUT (.i_core_clk(clk), .i_sys_rst(rst), .i_ce(ce), .i_start(start),
    .i_sample(smp), .i_ready(rdy), .o_byte(ob), .o_busy(busy), .o_timestamp(ts));
  itf_host_model host (.i_core_clk(clk), .i_ce(ce), .i_slow(slow), .i_byte(ob),
    .o_ready(rdy));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // own bitwise model, msb first, so a wrong step in the design's itf_crc_step shows up
  function automatic logic [31:0] crc_of(input logic [159:0] f);
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    for (int i = 159; i >= 0; i--)
      c = {c[30:0], 1'b0} ^ ((c[31] ^ f[i]) ? 32'h04C11DB7 : 32'h0);
    return c;
  endfunction
  task automatic run_tail(input itf_row_t r);
    logic [191:0] t;
    int n0;
    int k;
    n0 = host.n;
    slow = r.slow;
    smp = r.s;
    start = 1;
    #6 ts_seen = ts;
    @(posedge clk) #1 start = 0;
    repeat (7) @(posedge clk);
    #1 start = r.poke;
    @(posedge clk) #1 start = 0;
    if (r.gap > 0)
    begin
      ce = 0;
      repeat (r.gap) @(posedge clk);
      #1 ce = 1;
    end
    for (k = 0; k < 400 && busy !== 1'b0; k++)
    begin
      @(posedge clk);
      #1;
    end
    check(busy, 0);
    repeat (6) @(posedge clk);
    #1 t = {16'h00F4, 16'h06D6, ts_seen, r.s, 32'h0};
    t[31:0] = crc_of(t[191:32]);
    for (int i = 0; i < 24; i++)
      check(host.rx[(n0+i)%24], t[191-8*i-:8]);
    check(host.n - n0, 24);
    check(host.last_n - n0, 23);
    check(ob.valid, 0);
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #200000;
    bad_count++;
    report_and_stop();
  end
  initial
  begin
    repeat (6) @(posedge clk);
    #1 check(ts, 0);
    check(busy, 0);
    rst = 0;
    // 3125 cycles make one 25 us step
    repeat (3100) @(posedge clk);
    #1 check(ts, 0);
    repeat (100) @(posedge clk);
    #1 check(ts, 1);
    foreach (rows[i])
      run_tail(rows[i]);
    // reset in mid-tail drops the stream and the timestamp
    start = 1;
    @(posedge clk) #1 start = 0;
    repeat (9) @(posedge clk);
    #1 rst = 1;
    @(posedge clk) #1 rst = 0;
    check(busy, 0);
    check(ob, 0);
    check(ts, 0);
    run_tail(rows[2]);
    report_and_stop();
  end
endmodule

// ---- verification/itf_host_model.sv ----
// itf_host_model: host-side sink that takes tail bytes and keeps them.
// assumes the byte carrier of itf_pkg and the framer's core clock.
`timescale 1ns/10ps
module itf_host_model (
  input wire logic i_core_clk,
  input wire logic i_ce,
  input wire logic i_slow,
  input wire itf_pkg::itf_byte_t i_byte,
  output logic o_ready
);
  logic [7:0] rx [0:23];
  int n = 0;
  int last_n = 0;
  int phase = 0;
  // slow host stalls two cycles in three
  always_comb o_ready = !i_slow || (phase == 2);
  always @(posedge i_core_clk)
  begin
    phase <= (phase + 1) % 3;
    if (i_byte.valid && o_ready && i_ce)
    begin
      rx[n % 24] <= i_byte.data;
      n <= n + 1;
      if (i_byte.last)
        last_n <= n;
    end
  end
endmodule
